// File: design/agc_defines.svh
`ifndef AGC_DEFINES_SVH
`define AGC_DEFINES_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define PAGE_CTRL 8'h00
`define PAGE_COEF 8'h04
`define OFF_ENABLE_TARGET 7'h56
`define OFF_HYST_THRESHOLD 7'h57
`define OFF_MAX_GAIN 7'h58
`define OFF_ATTACK_TIME 7'h59
`define OFF_DECAY_TIME 7'h5a
`define OFF_NOISE_DEBOUNCE 7'h5b
`define OFF_SIGNAL_DEBOUNCE 7'h5c
`define OFF_APPLIED_GAIN 7'h5d
`define OFF_STATUS 7'h5e
`define OFF_N0_HI 7'h02
`define OFF_N0_LO 7'h03
`define OFF_N1_HI 7'h04
`define OFF_N1_LO 7'h05
`define OFF_D1_HI 7'h06
`define OFF_D1_LO 7'h07
`define RST_CTRL_REG 8'h00
`define RST_N0 16'h7fff
`define RST_N1 16'h0000
`define RST_D1 16'h0000
// ----------------------------------------
// fields and levels
// ----------------------------------------
`define ENABLE_BIT 7
`define STATUS_NOISE_BIT 6
`define STATUS_LOOP_SAT_BIT 5
`define STATUS_CONV_SAT_BIT 3
`define HYST_OFF 2'h3
`define GAIN_CEIL 7'h77
`define TGT_0 16'h43f1
`define TGT_1 16'h32f5
`define TGT_2 16'h287a
`define TGT_3 16'h2027
`define TGT_4 16'h198a
`define TGT_5 16'h1214
`define TGT_6 16'h0ccd
`define TGT_7 16'h0814
`define NOISE_BASE 32'h00040c37
`define NOISE_STEP_MUL 32'h000000cb
`define ATTACK_BASE_SHIFT 4'h5
`define DECAY_BASE_SHIFT 4'h9
`define TC_STEP_SHIFT 4
`define TC_W 20
`endif

// File: design/agc_pkg.sv
package agc_pkg;
  typedef enum logic [1:0] {LOOP_OFF, TRACKING, SILENCE} loop_state_t;

  typedef struct packed {
    logic signed [24:0] x_prev;
    logic [23:0] y;
    logic out_valid;
  } filter_state_t;

  typedef struct packed {
    logic [19:0] cnt;
  } pacer_state_t;

  typedef struct packed {
    logic [7:0] enable_target;
    logic [7:0] hyst_thr;
    logic [7:0] max_gain;
    logic [7:0] attack;
    logic [7:0] decay;
    logic [7:0] noise_deb;
    logic [7:0] signal_deb;
    logic [15:0] n0;
    logic [15:0] n1;
    logic [15:0] d1;
    loop_state_t mode;
    logic [6:0] loop_gain;
    logic [7:0] deb_cnt;
    logic [1:0] last_dir;
    logic noise_flag;
    logic loop_sat;
    logic conv_sat;
    logic [6:0] out_gain;
    logic [7:0] rdata;
  } core_state_t;
endpackage

// File: design/agc_level_filter.sv
`timescale 1ns/1ps
`include "agc_defines.svh"
module agc_level_filter
  import agc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic sample_valid,
  input wire logic signed [15:0] sample_data,
  input wire logic signed [15:0] coef_n0,
  input wire logic signed [15:0] coef_n1,
  input wire logic signed [15:0] coef_d1,
  output logic [23:0] level,
  output logic level_valid
);
  filter_state_t state;
  filter_state_t next_state;

  // -32768 wraps to 0x8000, which is still the right unsigned magnitude
  function automatic logic [15:0] magnitude(input logic signed [15:0] s);
    return s[15] ? 16'(-s) : 16'(s);
  endfunction

  // first-order iir on the rectified sample, eight guard bits below
  always_comb begin
    logic signed [24:0] x;
    logic signed [42:0] acc;
    x = '0;
    acc = '0;
    next_state = state;
    next_state.out_valid = 1'b0;
    x = $signed({1'b0, magnitude(sample_data), 8'h00});
    acc = coef_n0 * x + coef_n1 * state.x_prev + coef_d1 * $signed({1'b0, state.y});
    if (sample_valid) begin
      next_state.x_prev = x;
      next_state.out_valid = 1'b1;
      // a negative average makes no sense as a level, clip it to zero
      if (acc[42]) begin
        next_state.y = '0;
      end else if (|acc[41:39]) begin
        next_state.y = 24'hffffff;
      end else begin
        next_state.y = acc[38:15];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign level = state.y;
  assign level_valid = state.out_valid;

  property p_rectified_pass;
    @(posedge clk) disable iff (reset)
    sample_valid && coef_n0 == 16'sh7fff && coef_n1 == 16'sh0000 && coef_d1 == 16'sh0000
      |=> level_valid && level <= {$past(magnitude(sample_data)), 8'h00} && level[23] == 1'b0;
  endproperty
  a_rectified_pass: assert property (p_rectified_pass) else $error("level not the rectified sample");
endmodule

// File: design/agc_step_pacer.sv
`timescale 1ns/1ps
`include "agc_defines.svh"
module agc_step_pacer
  import agc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic sample_tick,
  input wire logic restart,
  input wire logic [`TC_W-1:0] interval,
  output logic step
);
  pacer_state_t state;
  pacer_state_t next_state;

  // step is combinational so the gain moves in the same sample it is due
  assign step = sample_tick && !restart && (state.cnt + 20'h1 >= interval);

  // count samples spent in one direction; a change of direction starts over
  always_comb begin
    next_state = state;
    if (restart) begin
      next_state.cnt = '0;
    end else if (sample_tick) begin
      next_state.cnt = step ? 20'h0 : state.cnt + 20'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
endmodule

// File: design/agc_core.sv
`timescale 1ns/1ps
`include "agc_defines.svh"
module agc_core
  import agc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] reg_page,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic sample_valid,
  input wire logic signed [15:0] sample_data,
  input wire logic converter_saturated,
  input wire logic [6:0] fixed_gain,
  output logic [6:0] mic_preamp_gain
);
  core_state_t state;
  core_state_t next_state;
  logic [23:0] lvl;
  logic lvl_valid;
  logic en;
  logic [23:0] target_lvl;
  logic [24:0] target_hi;
  logic [23:0] noise_lvl;
  logic [24:0] exit_lvl;
  logic [6:0] limit;
  logic too_loud;
  logic too_low;
  logic below_noise;
  logic above_exit;
  logic [`TC_W-1:0] attack_samples;
  logic [`TC_W-1:0] decay_samples;
  logic [`TC_W-1:0] pace_interval;
  logic pace_tick;
  logic pace_restart;
  logic pace_step;
  logic [7:0] ndeb_lim;
  logic [7:0] sdeb_lim;

  // ----------------------------------------
  // level decoding
  // ----------------------------------------
  function automatic logic [23:0] target_level(input logic [2:0] code);
    logic [15:0] t;
    t = `TGT_0;
    case (code)
      3'h0: t = `TGT_0;
      3'h1: t = `TGT_1;
      3'h2: t = `TGT_2;
      3'h3: t = `TGT_3;
      3'h4: t = `TGT_4;
      3'h5: t = `TGT_5;
      3'h6: t = `TGT_6;
      default: t = `TGT_7;
    endcase
    return {t, 8'h00};
  endfunction

  // 2 db per code from -30 db; long multiplier chain traded for no table
  function automatic logic [23:0] noise_level(input logic [4:0] code);
    logic [31:0] t;
    t = `NOISE_BASE;
    for (int i = 1; i < 31; i++) begin
      if (i < int'(code)) begin
        t = (t * `NOISE_STEP_MUL) >> 8;
      end
    end
    return t[23:0];
  endfunction

  // exit level sits above the threshold so the loop cannot chatter, except code 3 which puts it at the threshold
  function automatic logic [24:0] with_hyst(input logic [23:0] thr, input logic [1:0] code);
    logic [24:0] h;
    h = {1'b0, thr};
    case (code)
      2'h0: h = {1'b0, thr} + 25'(thr >> 3);
      2'h1: h = {1'b0, thr} + 25'(thr >> 2);
      2'h2: h = {1'b0, thr} + 25'(thr >> 1) + 25'(thr >> 4);
      default: h = {1'b0, thr};
    endcase
    return h;
  endfunction

  // odd mantissa from the top five bits, scaled by base and bits 2..1
  function automatic logic [`TC_W-1:0] tc_samples(input logic [7:0] code, input logic [3:0] base);
    logic [`TC_W-1:0] m;
    m = `TC_W'({code[7:3], 1'b1});
    return m << (base + {2'h0, code[2:1]});
  endfunction

  // ----------------------------------------
  // averager and step pacing
  // ----------------------------------------
  agc_level_filter u_filter (
    .clk(clk),
    .reset(reset),
    .sample_valid(sample_valid),
    .sample_data(sample_data),
    .coef_n0(state.n0),
    .coef_n1(state.n1),
    .coef_d1(state.d1),
    .level(lvl),
    .level_valid(lvl_valid)
  );

  agc_step_pacer u_pacer (
    .clk(clk),
    .reset(reset),
    .sample_tick(pace_tick),
    .restart(pace_restart),
    .interval(pace_interval),
    .step(pace_step)
  );

  // decision terms, all judged on the averaged level
  assign en = state.enable_target[`ENABLE_BIT];
  assign target_lvl = target_level(state.enable_target[6:4]);
  assign target_hi = {1'b0, target_lvl} + 25'(target_lvl >> 3);
  assign too_loud = {1'b0, lvl} > target_hi;
  assign too_low = lvl < target_lvl;
  assign noise_lvl = noise_level(state.hyst_thr[5:1]);
  assign exit_lvl = with_hyst(noise_lvl, state.hyst_thr[7:6]);
  assign below_noise = state.hyst_thr[5:1] != 5'h0 && lvl < noise_lvl;
  assign above_exit = {1'b0, lvl} >= exit_lvl;
  assign limit = state.max_gain[6:0] > `GAIN_CEIL ? `GAIN_CEIL : state.max_gain[6:0];
  assign attack_samples = tc_samples(state.attack, `ATTACK_BASE_SHIFT);
  assign decay_samples = tc_samples(state.decay, `DECAY_BASE_SHIFT);
  assign pace_interval = (too_loud ? attack_samples : decay_samples) >> `TC_STEP_SHIFT;
  assign pace_tick = lvl_valid && state.mode == TRACKING && (too_loud || too_low);
  assign pace_restart = lvl_valid && {too_loud, too_low} != state.last_dir;
  assign ndeb_lim = {1'b0, state.noise_deb[4:0], 2'h0};
  assign sdeb_lim = {2'h0, state.signal_deb[3:0], 2'h0};

  // ----------------------------------------
  // registers and loop
  // ----------------------------------------
  always_comb begin
    next_state = state;
    // register writes
    if (reg_wr && reg_page == `PAGE_CTRL) begin
      case (reg_addr)
        `OFF_ENABLE_TARGET: next_state.enable_target = reg_wdata;
        `OFF_HYST_THRESHOLD: next_state.hyst_thr = reg_wdata;
        `OFF_MAX_GAIN: next_state.max_gain = reg_wdata;
        `OFF_ATTACK_TIME: next_state.attack = reg_wdata;
        `OFF_DECAY_TIME: next_state.decay = reg_wdata;
        `OFF_NOISE_DEBOUNCE: next_state.noise_deb = reg_wdata;
        `OFF_SIGNAL_DEBOUNCE: next_state.signal_deb = reg_wdata;
        default: next_state.rdata = state.rdata;
      endcase
    end
    // coefficients are assembled high byte then low byte
    if (reg_wr && reg_page == `PAGE_COEF) begin
      case (reg_addr)
        `OFF_N0_HI: next_state.n0[15:8] = reg_wdata;
        `OFF_N0_LO: next_state.n0[7:0] = reg_wdata;
        `OFF_N1_HI: next_state.n1[15:8] = reg_wdata;
        `OFF_N1_LO: next_state.n1[7:0] = reg_wdata;
        `OFF_D1_HI: next_state.d1[15:8] = reg_wdata;
        `OFF_D1_LO: next_state.d1[7:0] = reg_wdata;
        default: next_state.rdata = state.rdata;
      endcase
    end
    // reads answer on the next edge; unmapped addresses read zero
    if (reg_rd) begin
      next_state.rdata = 8'h00;
      if (reg_page == `PAGE_CTRL) begin
        case (reg_addr)
          `OFF_ENABLE_TARGET: next_state.rdata = state.enable_target;
          `OFF_HYST_THRESHOLD: next_state.rdata = state.hyst_thr;
          `OFF_MAX_GAIN: next_state.rdata = state.max_gain;
          `OFF_ATTACK_TIME: next_state.rdata = state.attack;
          `OFF_DECAY_TIME: next_state.rdata = state.decay;
          `OFF_NOISE_DEBOUNCE: next_state.rdata = state.noise_deb;
          `OFF_SIGNAL_DEBOUNCE: next_state.rdata = state.signal_deb;
          `OFF_APPLIED_GAIN: next_state.rdata = {1'b0, state.loop_gain};
          `OFF_STATUS: next_state.rdata = {1'b0, state.noise_flag, state.loop_sat, 1'b0, state.conv_sat, 3'h0};
          default: next_state.rdata = 8'h00;
        endcase
      end else if (reg_page == `PAGE_COEF) begin
        case (reg_addr)
          `OFF_N0_HI: next_state.rdata = state.n0[15:8];
          `OFF_N0_LO: next_state.rdata = state.n0[7:0];
          `OFF_N1_HI: next_state.rdata = state.n1[15:8];
          `OFF_N1_LO: next_state.rdata = state.n1[7:0];
          `OFF_D1_HI: next_state.rdata = state.d1[15:8];
          `OFF_D1_LO: next_state.rdata = state.d1[7:0];
          default: next_state.rdata = 8'h00;
        endcase
      end
    end
    next_state.conv_sat = converter_saturated;
    // one decision per averaged sample
    if (lvl_valid) begin
      case (state.mode)
        LOOP_OFF: begin
          next_state.loop_gain = 7'h00;
        end
        TRACKING: begin
          next_state.last_dir = {too_loud, too_low};
          // quiet input must persist for the debounce before silence
          if (below_noise) begin
            if (state.deb_cnt >= ndeb_lim) begin
              next_state.mode = SILENCE;
              next_state.noise_flag = 1'b1;
              next_state.deb_cnt = 8'h00;
            end else begin
              next_state.deb_cnt = state.deb_cnt + 8'h01;
            end
          end else begin
            next_state.deb_cnt = 8'h00;
          end
          if (pace_step && too_loud && state.loop_gain != 7'h00) begin
            next_state.loop_gain = state.loop_gain - 7'h01;
          end else if (pace_step && too_low && state.loop_gain < limit) begin
            next_state.loop_gain = state.loop_gain + 7'h01;
          end
          next_state.loop_sat = (too_low && state.loop_gain >= limit) || (too_loud && state.loop_gain == 7'h00);
        end
        SILENCE: begin
          next_state.last_dir = 2'h0;
          if (state.loop_gain != 7'h00) begin
            next_state.loop_gain = state.loop_gain - 7'h01;
          end
          // stay at 0 db until the level clears the hysteresis band
          if (above_exit) begin
            if (state.deb_cnt >= sdeb_lim) begin
              next_state.mode = TRACKING;
              next_state.noise_flag = 1'b0;
              next_state.deb_cnt = 8'h00;
            end else begin
              next_state.deb_cnt = state.deb_cnt + 8'h01;
            end
          end else begin
            next_state.deb_cnt = 8'h00;
          end
        end
        default: begin
          next_state.mode = LOOP_OFF;
        end
      endcase
    end
    // disabling drops all loop state so a new enable starts at 0 db
    if (!en) begin
      next_state.mode = LOOP_OFF;
      next_state.loop_gain = 7'h00;
      next_state.noise_flag = 1'b0;
      next_state.loop_sat = 1'b0;
      next_state.deb_cnt = 8'h00;
      next_state.last_dir = 2'h0;
    end else if (state.mode == LOOP_OFF) begin
      next_state.mode = TRACKING;
    end
    // a lowered maximum takes effect at once
    if (next_state.loop_gain > limit) begin
      next_state.loop_gain = limit;
    end
    // same preamp gain, fixed value when the loop is off
    next_state.out_gain = en ? next_state.loop_gain : fixed_gain;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= '0;
      state.n0 <= `RST_N0;
      state.n1 <= `RST_N1;
      state.d1 <= `RST_D1;
      state.enable_target <= `RST_CTRL_REG;
      state.max_gain <= `RST_CTRL_REG;
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata = state.rdata;
  assign mic_preamp_gain = state.out_gain;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_tracking_sample;
    lvl_valid && en && !reg_wr && state.mode == TRACKING;
  endsequence

  sequence s_silence_sample;
    lvl_valid && en && !reg_wr && state.mode == SILENCE;
  endsequence

  property p_gain_ceiling;
    !$past(reg_wr) |-> state.loop_gain <= limit;
  endproperty
  a_gain_ceiling: assert property (p_gain_ceiling) else $error("gain above maximum");

  property p_sample_paced;
    $changed(state.loop_gain) && en && $past(en) |-> $past(lvl_valid) || $past(reg_wr, 2);
  endproperty
  a_sample_paced: assert property (p_sample_paced) else $error("gain moved off a sample");

  property p_silence_ramp;
    s_silence_sample ##0 state.loop_gain != 7'h00 |=> state.loop_gain == $past(state.loop_gain) - 7'h01;
  endproperty
  a_silence_ramp: assert property (p_silence_ramp) else $error("silence did not step down");

  property p_silence_hold;
    state.mode == SILENCE && state.loop_gain == 7'h00 && en |=> state.loop_gain == 7'h00;
  endproperty
  a_silence_hold: assert property (p_silence_hold) else $error("gain left 0 db in silence");

  property p_noise_entry;
    $rose(state.noise_flag) |-> $past(lvl_valid && below_noise && state.deb_cnt >= ndeb_lim);
  endproperty
  a_noise_entry: assert property (p_noise_entry) else $error("silence entered without debounce");

  property p_attack_step;
    s_tracking_sample ##0 pace_step && too_loud && state.loop_gain != 7'h00
      |=> state.loop_gain == $past(state.loop_gain) - 7'h01;
  endproperty
  a_attack_step: assert property (p_attack_step) else $error("attack step missing");

  property p_decay_step;
    s_tracking_sample ##0 pace_step && too_low && state.loop_gain < limit
      |=> state.loop_gain == $past(state.loop_gain) + 7'h01;
  endproperty
  a_decay_step: assert property (p_decay_step) else $error("decay step missing");

  property p_ctrl_write;
    reg_wr && reg_page == `PAGE_CTRL && reg_addr == `OFF_ENABLE_TARGET && reg_wdata == 8'ha0
      |=> en && state.enable_target[6:4] == 3'h2 ##1 state.mode == TRACKING;
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("enable write not taken");

  property p_applied_read;
    reg_rd && reg_page == `PAGE_CTRL && reg_addr == `OFF_APPLIED_GAIN
      |=> reg_rdata == {1'b0, $past(state.loop_gain)};
  endproperty
  a_applied_read: assert property (p_applied_read) else $error("applied gain read wrong");

  property p_status_read;
    reg_rd && reg_page == `PAGE_CTRL && reg_addr == `OFF_STATUS
      |=> reg_rdata[`STATUS_NOISE_BIT] == $past(state.noise_flag)
          && reg_rdata[`STATUS_LOOP_SAT_BIT] == $past(state.loop_sat)
          && reg_rdata[`STATUS_CONV_SAT_BIT] == $past(state.conv_sat);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");

  property p_tc_codes;
    (state.attack == 8'h68 |-> attack_samples == 20'd864) and (state.decay == 8'ha8 |-> decay_samples == 20'd22016);
  endproperty
  a_tc_codes: assert property (p_tc_codes) else $error("time code scale wrong");

  property p_coef_write;
    reg_wr && reg_page == `PAGE_COEF && reg_addr == `OFF_N0_HI ##1 reg_wr && reg_page == `PAGE_COEF
      && reg_addr == `OFF_N0_LO |=> state.n0 == {$past(reg_wdata, 2), $past(reg_wdata)};
  endproperty
  a_coef_write: assert property (p_coef_write) else $error("coefficient not assembled");
endmodule

// File: verif/agc_sample_source.sv
`timescale 1ns/1ps
// ----------------------------------------
// converter sample path model
// ----------------------------------------
module agc_sample_source (
  input wire logic clk,
  input wire logic reset,
  input wire logic run,
  input wire logic signed [15:0] amplitude,
  output logic sample_valid,
  output logic signed [15:0] sample_data
);
  logic [1:0] div;
  logic neg;

  // one sample every four clocks; sign alternates so only magnitude carries level
  always_ff @(posedge clk) begin
    if (reset || !run) begin
      div <= 2'h0;
      neg <= 1'b0;
      sample_valid <= 1'b0;
      sample_data <= 16'sh0000;
    end else begin
      div <= div + 2'h1;
      sample_valid <= (div == 2'h3);
      if (div == 2'h3) begin
        neg <= ~neg;
        sample_data <= neg ? -amplitude : amplitude;
      end else begin
        sample_data <= ~sample_data; // stale data is never a stable value
      end
    end
  end
endmodule

// File: verif/test_mic_automatic_gain_control.sv
`timescale 1ns/1ps
module test_mic_automatic_gain_control;
  import agc_pkg::*;
  logic clk, reset, reg_wr, reg_rd, run, converter_saturated, sample_valid, mon_on;
  logic [7:0] reg_page, reg_wdata, reg_rdata, rv, pg;
  logic [6:0] reg_addr, fixed_gain, mic_preamp_gain, prev_gain;
  logic signed [15:0] amplitude, sample_data;
  int failures, checks_done, cycles, n_samples, step_at, gap;

  agc_core agc_core_i (.clk(clk), .reset(reset), .reg_page(reg_page), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sample_valid(sample_valid), .sample_data(sample_data),
    .converter_saturated(converter_saturated), .fixed_gain(fixed_gain), .mic_preamp_gain(mic_preamp_gain));
  agc_sample_source agc_sample_source_i (.clk(clk), .reset(reset), .run(run), .amplitude(amplitude),
    .sample_valid(sample_valid), .sample_data(sample_data));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_page <= pg;
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // two extra edges before sampling so read data has surely landed
  task automatic rd(input logic [6:0] a);
    @(posedge clk);
    reg_page <= pg;
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    repeat (2) @(posedge clk);
    rv = reg_rdata;
  endtask
  task automatic samples(input int n);
    repeat (n) @(posedge clk iff sample_valid);
    repeat (3) @(posedge clk);
  endtask
  task automatic wait_gain(input logic [6:0] g, input int limit);
    for (int i = 0; i < limit && mic_preamp_gain !== g; i++) @(posedge clk);
    @(posedge clk);
    check("gain reached", {1'b0, mic_preamp_gain}, {1'b0, g});
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // step spacing in samples, step size, and the hang limit
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (sample_valid) n_samples <= n_samples + 1;
    if (mic_preamp_gain !== prev_gain) begin
      gap <= n_samples - step_at;
      step_at <= n_samples;
      if (mon_on) check("gain step", {1'b0, (mic_preamp_gain > prev_gain) ? mic_preamp_gain - prev_gain :
        prev_gain - mic_preamp_gain}, 8'h01);
    end
    prev_gain <= mic_preamp_gain;
    if (cycles == 20000) begin
      failures++;
      wrap_up();
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic sc_reset_map();
    check("fixed gain", {1'b0, mic_preamp_gain}, 8'h0a);
    for (logic [7:0] a = 8'h56; a <= 8'h5e; a++) begin
      rd(a[6:0]);
      check("reset value", rv, 8'h00);
    end
    wr(7'h60, 8'h5a);
    rd(7'h60);
    check("unmapped read", rv, 8'h00);
  endtask
  // configure fully before any sample flows; enable with -10 dB target
  task automatic sc_config();
    logic [7:0] vals [7] = '{8'ha0, 8'hc0, 8'h04, 8'h00, 8'h00, 8'h02, 8'h00};
    fixed_gain <= 7'h00;
    for (int i = 0; i < 7; i++) wr(7'h56 + 7'(i), vals[i]);
    for (int i = 0; i < 7; i++) begin
      rd(7'h56 + 7'(i));
      check("config readback", rv, vals[i]);
    end
    wr(7'h5d, 8'h55);
    rd(7'h5d);
    check("applied gain read only", rv, 8'h00);
    mon_on = 1'b1;
  endtask
  task automatic sc_decay();
    amplitude <= 16'sh0010;
    run <= 1'b1;
    wait_gain(7'h04, 2000);
    check("decay pace", 8'(gap), 8'h20);
    samples(100);
    check("max gain hold", {1'b0, mic_preamp_gain}, 8'h04);
    rd(7'h5d);
    check("applied gain", rv, 8'h04);
    rd(7'h5e);
    check("loop saturation high", rv, 8'h20);
  endtask
  task automatic sc_attack();
    wr(7'h59, 8'h68);
    amplitude <= 16'sh7000;
    wait_gain(7'h02, 2000);
    check("attack pace", 8'(gap), 8'h36);
    wait_gain(7'h00, 1000);
    samples(4);
    rd(7'h5e);
    check("loop saturation low", rv, 8'h20);
  endtask
  // quiet input with a -30 dB threshold and an eight-sample noise debounce
  task automatic sc_silence();
    wr(7'h59, 8'h00);
    amplitude <= 16'sh0010;
    wait_gain(7'h04, 2000);
    wr(7'h57, 8'hc2);
    samples(6);
    check("noise debounce", {1'b0, mic_preamp_gain}, 8'h04);
    wait_gain(7'h00, 200);
    check("silence pace", 8'(gap), 8'h01);
    rd(7'h5e);
    check("noise flag", rv & 8'h40, 8'h40);
    samples(40);
    check("silence holds", {1'b0, mic_preamp_gain}, 8'h00);
    amplitude <= 16'sh2000;
    wait_gain(7'h01, 2000);
    rd(7'h5e);
    check("noise flag cleared", rv & 8'h40, 8'h00);
  endtask
  task automatic sc_status_disable();
    // -14 dB target sits below the present level, so the loop must turn downward
    wr(7'h56, 8'hc0);
    wait_gain(7'h00, 200);
    converter_saturated <= 1'b1;
    rd(7'h5e);
    check("converter saturation", rv & 8'h08, 8'h08);
    converter_saturated <= 1'b0;
    rd(7'h5e);
    check("converter saturation live", rv & 8'h08, 8'h00);
    mon_on = 1'b0;
    wr(7'h56, 8'h20);
    fixed_gain <= 7'h33;
    samples(2);
    check("fixed gain when off", {1'b0, mic_preamp_gain}, 8'h33);
  endtask
  // n0 as two back-to-back bytes on the coefficient page, then byte readback
  task automatic sc_coef();
    wr(7'h5a, 8'ha8);
    pg = 8'h04;
    @(posedge clk);
    reg_page <= pg;
    reg_addr <= 7'h02;
    reg_wdata <= 8'h12;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_addr <= 7'h03;
    reg_wdata <= 8'h34;
    @(posedge clk);
    reg_wr <= 1'b0;
    rd(7'h02);
    check("n0 high byte", rv, 8'h12);
    rd(7'h03);
    check("n0 low byte", rv, 8'h34);
    wr(7'h07, 8'h56);
    rd(7'h07);
    check("d1 low byte", rv, 8'h56);
    rd(7'h06);
    check("d1 high byte", rv, 8'h00);
    pg = 8'h00;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // reset, then the scenarios in order; the loop state carries between them
  initial begin
    reset = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_page = 8'h00;
    pg = 8'h00;
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
    run = 1'b0;
    amplitude = 16'sh0000;
    converter_saturated = 1'b0;
    fixed_gain = 7'h0a;
    mon_on = 1'b0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    sc_reset_map();
    sc_config();
    sc_decay();
    sc_attack();
    sc_silence();
    sc_status_disable();
    sc_coef();
    wrap_up();
  end
endmodule
